/* File: rtl/rxes_top.sv */
`timescale 1ns/1ps
module rxes_top
  import rxes_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic txEnable,
  input wire logic rxEnable,
  input wire logic [EOF_LEN_W-1:0] eofLength,
  input wire logic [CHANNELS-1:0] bitTick,
  input wire logic [CHANNELS-1:0] bitValid,
  input wire logic [CHANNELS-1:0] bitData,
  input wire logic [7:0] hostAddr,
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [7:0] hostWriteData,
  output logic [7:0] readData,
  output logic readValid,
  output logic irq
);

  // *****************************************************************
  // Declarations
  // *****************************************************************
  logic rxMode;
  logic flagsRead;
  logic [7:0] eventFlags;
  logic [7:0] rxIrqEnable;
  logic [7:0] next_readData;
  logic [CHANNELS-1:0] dataRead;
  logic [CHANNELS-1:0] eofEvent;
  logic [CHANNELS-1:0] frameActive;
  logic [CHANNELS-1:0] loadPulse;
  logic [CHANNELS-1:0] holdFull;
  logic [7:0] holdData [CHANNELS];
  logic [7:0] holdMask [CHANNELS];
  logic [3:0] chFlags [CHANNELS];

  // Receive mode only with receive on and transmit off
  assign rxMode = rxEnable && !txEnable;
  assign flagsRead = hostRead && (hostAddr == ADDR_RX_EVENT_FLAGS);
  assign dataRead[0] = hostRead && (hostAddr == ADDR_RX_DATA_A);
  assign dataRead[1] = hostRead && (hostAddr == ADDR_RX_DATA_B);

  // *****************************************************************
  // Channels
  // *****************************************************************
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      rxes_eof_timer u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .clear(!rxMode),
        .bitTick(bitTick[ch]),
        .bitValid(bitValid[ch]),
        .eofLength(eofLength),
        .frameActive(frameActive[ch]),
        .eofEvent(eofEvent[ch])
      );

      rxes_channel u_chan (
        .clock(clock),
        .reset_n(reset_n),
        .rxMode(rxMode),
        .bitTick(bitTick[ch]),
        .bitValid(bitValid[ch]),
        .bitData(bitData[ch]),
        .eofEvent(eofEvent[ch]),
        .dataRead(dataRead[ch]),
        .flagsRead(flagsRead),
        .holdData(holdData[ch]),
        .holdMask(holdMask[ch]),
        .holdFull(holdFull[ch]),
        .loadPulse(loadPulse[ch]),
        .flags(chFlags[ch])
      );

      // Channel fields packed into the status byte
      assign eventFlags[ch*CH_STRIDE +: CH_STRIDE] = chFlags[ch];
    end
  endgenerate

  // *****************************************************************
  // Register port
  // *****************************************************************

  // Only the enable register takes writes; the status byte is read-only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxIrqEnable <= RESET_IRQ_ENABLE;
    end else if (hostWrite && hostAddr == ADDR_RX_IRQ_ENABLE) begin
      rxIrqEnable <= hostWriteData;
    end
  end

  // Read mux; status captured before the read clear takes effect
  always_comb begin
    case (hostAddr)
      ADDR_RX_IRQ_ENABLE: next_readData = rxIrqEnable;
      ADDR_RX_EVENT_FLAGS: next_readData = rxMode ? eventFlags : RESET_EVENT_FLAGS;
      ADDR_RX_DATA_A: next_readData = holdData[0];
      ADDR_RX_MASK_A: next_readData = holdMask[0];
      ADDR_RX_DATA_B: next_readData = holdData[1];
      ADDR_RX_MASK_B: next_readData = holdMask[1];
      default: next_readData = RESET_BYTE;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readData <= RESET_BYTE;
      readValid <= 1'b0;
    end else begin
      readValid <= hostRead;
      if (hostRead) begin
        readData <= next_readData;
      end
    end
  end

  // *****************************************************************
  // Interrupt
  // *****************************************************************

  // Registered so the pin never glitches on flag updates
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventFlags & rxIrqEnable & IRQ_CAPABLE);
    end
  end

  // *****************************************************************
  // Assertions
  // *****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_status_read;
    hostRead && hostAddr == ADDR_RX_EVENT_FLAGS;
  endsequence

  sequence s_enable_write;
    hostWrite && hostAddr == ADDR_RX_IRQ_ENABLE;
  endsequence

  property p_not_rx_zero;
    !rxMode |=> eventFlags == RESET_EVENT_FLAGS;
  endproperty
  a_not_rx_zero: assert property (p_not_rx_zero) else $error("flags not zero outside receive mode");

  property p_status_read_masked;
    s_status_read and !rxMode |=> readValid && readData == RESET_EVENT_FLAGS;
  endproperty
  a_status_read_masked: assert property (p_status_read_masked) else $error("status read nonzero outside rx mode");

  property p_write_ignored;
    hostWrite && !hostRead && hostAddr == ADDR_RX_EVENT_FLAGS && rxMode && loadPulse == '0 && eofEvent == '0
      && !(|(dataRead & ~holdFull)) |=> eventFlags == $past(eventFlags);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("status write changed flags");

  property p_enable_write;
    s_enable_write |=> rxIrqEnable == $past(hostWriteData);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable register missed write");

  property p_irq_masked;
    ##1 irq == $past(|(eventFlags & rxIrqEnable & IRQ_CAPABLE));
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt does not match enabled flags");

  property p_valid_no_irq;
    (eventFlags & IRQ_CAPABLE) == RESET_EVENT_FLAGS |=> !irq;
  endproperty
  a_valid_no_irq: assert property (p_valid_no_irq) else $error("byte-complete raised interrupt");

  property p_read_clears;
    s_status_read and rxMode && loadPulse == '0 && eofEvent == '0 && !(|(dataRead & ~holdFull))
      |=> (eventFlags & IRQ_CAPABLE) == RESET_EVENT_FLAGS;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read left pending flags");

  // Read answer carries the flags as they stood in the request cycle
  property p_status_read_value;
    s_status_read and rxMode |=> readValid && readData == $past(eventFlags);
  endproperty
  a_status_read_value: assert property (p_status_read_value) else $error("wrong status read");

  // Byte-complete bits survive a status read; only a load moves them
  property p_valid_kept;
    s_status_read and rxMode && loadPulse == '0
      |=> (eventFlags & ~IRQ_CAPABLE) == $past(eventFlags & ~IRQ_CAPABLE);
  endproperty
  a_valid_kept: assert property (p_valid_kept) else $error("byte-complete bit lost on read");

  // One answer for every read strobe and none without one
  property p_read_answer;
    hostRead |=> readValid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read strobe not answered");

  property p_no_stray_answer;
    !hostRead |=> !readValid;
  endproperty
  a_no_stray_answer: assert property (p_no_stray_answer) else $error("answer without read strobe");

  // Enable bits move only on a write to their own address
  property p_enable_kept;
    !(hostWrite && hostAddr == ADDR_RX_IRQ_ENABLE) |=> $stable(rxIrqEnable);
  endproperty
  a_enable_kept: assert property (p_enable_kept) else $error("enable register changed unasked");

  // No interrupt unless some capable enable bit was set the cycle before
  property p_irq_needs_enable;
    irq |-> $past(|(rxIrqEnable & IRQ_CAPABLE));
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("interrupt with nothing enabled");

  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_check
      localparam int BASE = ch * CH_STRIDE;

      sequence s_load;
        rxMode && loadPulse[ch];
      endsequence

      property p_load_sets_full;
        s_load |=> eventFlags[BASE + FLD_FULL] && holdFull[ch];
      endproperty
      a_load_sets_full: assert property (p_load_sets_full) else $error("load did not set full flag");

      property p_valid_flag;
        s_load |=> eventFlags[BASE + FLD_VALID] == (holdMask[ch] == ALL_BITS_VALID);
      endproperty
      a_valid_flag: assert property (p_valid_flag) else $error("byte-complete flag wrong");

      property p_overflow;
        s_load and holdFull[ch] && !dataRead[ch] |=> eventFlags[BASE + FLD_FLOW];
      endproperty
      a_overflow: assert property (p_overflow) else $error("overflow not flagged");

      property p_underflow;
        rxMode && dataRead[ch] && !holdFull[ch] |=> eventFlags[BASE + FLD_FLOW];
      endproperty
      a_underflow: assert property (p_underflow) else $error("underflow not flagged");

      property p_eof_flag;
        rxMode && eofEvent[ch] |=> eventFlags[BASE + FLD_EOF];
      endproperty
      a_eof_flag: assert property (p_eof_flag) else $error("end of frame not flagged");

      property p_eof_zero_len;
        rxMode && eofLength == '0 && frameActive[ch] && bitTick[ch] && !bitValid[ch] |-> eofEvent[ch];
      endproperty
      a_eof_zero_len: assert property (p_eof_zero_len) else $error("zero length missed end of frame");

      // A cut frame with bits pending loads a byte that is not complete
      property p_partial_load;
        rxMode && eofEvent[ch] && loadPulse[ch]
          |=> holdFull[ch] && eventFlags[BASE + FLD_FULL] && !eventFlags[BASE + FLD_VALID];
      endproperty
      a_partial_load: assert property (p_partial_load) else $error("partial byte not loaded");

      sequence s_full_rise;
        !eventFlags[BASE + FLD_FULL] ##1 eventFlags[BASE + FLD_FULL];
      endsequence

      // Data-loaded never rises without a load behind it
      property p_full_only_on_load;
        s_full_rise |-> $past(loadPulse[ch]);
      endproperty
      a_full_only_on_load: assert property (p_full_only_on_load) else $error("stray full flag");

      sequence s_flow_rise;
        !eventFlags[BASE + FLD_FLOW] ##1 eventFlags[BASE + FLD_FLOW];
      endsequence

      // Flow violation needs a load or a data read in the cycle before
      property p_flow_cause;
        s_flow_rise |-> $past(loadPulse[ch] || dataRead[ch]);
      endproperty
      a_flow_cause: assert property (p_flow_cause) else $error("stray flow flag");

      // End of frame only on an invalid bit time inside a frame
      property p_eof_cause;
        eofEvent[ch] |-> bitTick[ch] && !bitValid[ch] && frameActive[ch];
      endproperty
      a_eof_cause: assert property (p_eof_cause) else $error("stray end of frame");

      // Host read empties the holding register unless a load lands with it
      property p_read_empties;
        dataRead[ch] && !loadPulse[ch] |=> !holdFull[ch];
      endproperty
      a_read_empties: assert property (p_read_empties) else $error("data read left register full");

      // Leaving receive mode drops any held byte
      property p_not_rx_empty;
        !rxMode |=> !holdFull[ch];
      endproperty
      a_not_rx_empty: assert property (p_not_rx_empty) else $error("byte held outside receive mode");
    end
  endgenerate

endmodule : rxes_top

/* File: rtl/rxes_pkg.sv */
// *****************************************************************
// Receive event status constants
// *****************************************************************
package rxes_pkg;

  // Register offsets on the host register port
  localparam logic [7:0] ADDR_RX_IRQ_ENABLE = 8'h07;
  localparam logic [7:0] ADDR_RX_EVENT_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_RX_DATA_A = 8'h09;
  localparam logic [7:0] ADDR_RX_MASK_A = 8'h0a;
  localparam logic [7:0] ADDR_RX_DATA_B = 8'h0b;
  localparam logic [7:0] ADDR_RX_MASK_B = 8'h0c;

  // Values after reset
  localparam logic [7:0] RESET_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RESET_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_FIELD = 4'h0;

  // Field layout: channel A in bits 3:0, channel B in bits 7:4
  localparam int CHANNELS = 2;
  localparam int CH_STRIDE = 4;
  localparam int FLD_FULL = 0;
  localparam int FLD_EOF = 1;
  localparam int FLD_FLOW = 2;
  localparam int FLD_VALID = 3;

  // Bits that may drive the interrupt; byte-complete bits never do
  localparam logic [7:0] IRQ_CAPABLE = 8'h77;

  // Bit counting
  localparam int EOF_LEN_W = 4;
  localparam logic [3:0] LAST_BIT_POS = 4'h7;
  localparam logic [3:0] FIRST_BIT_POS = 4'h0;
  localparam logic [7:0] ALL_BITS_VALID = 8'hff;

endpackage : rxes_pkg

/* File: rtl/rxes_eof_timer.sv */
`timescale 1ns/1ps
// *****************************************************************
// End of frame timer: counts invalid bit times after reception began
// *****************************************************************
module rxes_eof_timer
  import rxes_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic bitTick,
  input wire logic bitValid,
  input wire logic [EOF_LEN_W-1:0] eofLength,
  output logic frameActive,
  output logic eofEvent
);

  typedef enum logic {RXES_WAIT, RXES_FRAME} rxes_frame_type;

  rxes_frame_type frameState;
  logic [EOF_LEN_W-1:0] invalidCount;

  // Event fires when this invalid bit takes the count past the length
  assign frameActive = (frameState == RXES_FRAME);
  assign eofEvent = !clear && bitTick && !bitValid && frameActive
    && (invalidCount == eofLength);

  // Frame state and invalid bit counter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frameState <= RXES_WAIT;
      invalidCount <= '0;
    end else if (clear) begin
      frameState <= RXES_WAIT;
      invalidCount <= '0;
    end else if (bitTick) begin
      case (frameState)
        RXES_WAIT: begin
          if (bitValid) begin
            frameState <= RXES_FRAME;
          end
          invalidCount <= '0;
        end
        RXES_FRAME: begin
          if (bitValid) begin
            invalidCount <= '0;
          end else if (invalidCount == eofLength) begin
            frameState <= RXES_WAIT;
            invalidCount <= '0;
          end else begin
            invalidCount <= invalidCount + 1'b1;
          end
        end
        default: begin
          frameState <= RXES_WAIT;
          invalidCount <= '0;
        end
      endcase
    end
  end

endmodule : rxes_eof_timer

/* File: rtl/rxes_channel.sv */
`timescale 1ns/1ps
// *****************************************************************
// One receive channel: byte assembly, holding register, event flags
// *****************************************************************
module rxes_channel
  import rxes_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic rxMode,
  input wire logic bitTick,
  input wire logic bitValid,
  input wire logic bitData,
  input wire logic eofEvent,
  input wire logic dataRead,
  input wire logic flagsRead,
  output logic [7:0] holdData,
  output logic [7:0] holdMask,
  output logic holdFull,
  output logic loadPulse,
  output logic [3:0] flags
);

  logic [7:0] shiftData;
  logic [7:0] shiftMask;
  logic [3:0] bitPos;
  logic [7:0] next_shiftData;
  logic [7:0] next_shiftMask;
  logic validBit;
  logic overflow;
  logic underflow;

  assign validBit = bitTick && bitValid;
  // A whole byte, or a partial one cut off by end of frame
  assign loadPulse = rxMode && ((validBit && bitPos == LAST_BIT_POS) || (eofEvent && bitPos != FIRST_BIT_POS));
  // Reading in the same cycle as a load empties the old byte first
  assign overflow = loadPulse && holdFull && !dataRead;
  assign underflow = rxMode && dataRead && !holdFull;

  // First received bit lands in bit 0
  always_comb begin
    next_shiftData = shiftData;
    next_shiftMask = shiftMask;
    if (validBit) begin
      next_shiftData[bitPos[2:0]] = bitData;
      next_shiftMask[bitPos[2:0]] = 1'b1;
    end
  end

  // Shift register and bit position
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shiftData <= RESET_BYTE;
      shiftMask <= RESET_BYTE;
      bitPos <= FIRST_BIT_POS;
    end else if (!rxMode || loadPulse) begin
      shiftData <= RESET_BYTE;
      shiftMask <= RESET_BYTE;
      bitPos <= FIRST_BIT_POS;
    end else if (validBit) begin
      shiftData <= next_shiftData;
      shiftMask <= next_shiftMask;
      bitPos <= bitPos + 1'b1;
    end
  end

  // Holding register seen by the host
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      holdData <= RESET_BYTE;
      holdMask <= RESET_BYTE;
      holdFull <= 1'b0;
    end else if (!rxMode) begin
      holdFull <= 1'b0;
    end else if (loadPulse) begin
      holdData <= next_shiftData;
      holdMask <= next_shiftMask;
      holdFull <= 1'b1;
    end else if (dataRead) begin
      holdFull <= 1'b0;
    end
  end

  // Event flags: a set in the clearing cycle wins over the read clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags <= RESET_FIELD;
    end else if (!rxMode) begin
      flags <= RESET_FIELD;
    end else begin
      if (loadPulse) begin
        flags[FLD_VALID] <= (next_shiftMask == ALL_BITS_VALID);
      end
      if (overflow || underflow) begin
        flags[FLD_FLOW] <= 1'b1;
      end else if (flagsRead) begin
        flags[FLD_FLOW] <= 1'b0;
      end
      if (eofEvent) begin
        flags[FLD_EOF] <= 1'b1;
      end else if (flagsRead) begin
        flags[FLD_EOF] <= 1'b0;
      end
      if (loadPulse) begin
        flags[FLD_FULL] <= 1'b1;
      end else if (flagsRead) begin
        flags[FLD_FULL] <= 1'b0;
      end
    end
  end

endmodule : rxes_channel

/* File: verification/rxes_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// Host side of the register port
// ****************************************
module rxes_host_model (
  input wire logic clock,
  output logic [7:0] hostAddr,
  output logic hostRead,
  output logic hostWrite,
  output logic [7:0] hostWriteData,
  input wire logic [7:0] readData,
  input wire logic readValid
);
  // Idle bus at time zero
  initial begin
    hostAddr = 8'h00;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    hostWriteData = 8'h00;
  end

  // One write; lines are scrambled afterwards so stale values cannot help
  task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    hostAddr <= addr;
    hostWriteData <= data;
    hostWrite <= 1'b1;
    @(posedge clock);
    hostWrite <= 1'b0;
    hostAddr <= ~addr;
    hostWriteData <= ~data;
  endtask : regWrite

  // One read; the answer must come exactly one cycle after the strobe
  task automatic regRead(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge clock);
    hostAddr <= addr;
    hostRead <= 1'b1;
    @(posedge clock);
    hostRead <= 1'b0;
    hostAddr <= ~addr;
    @(posedge clock);
    ok = (readValid === 1'b1);
    data = readData;
  endtask : regRead
endmodule : rxes_host_model

/* File: verification/tb_rx_serdes_event_status.sv */
`timescale 1ns/1ps
// ****************************************
// Receive event status bench
// ****************************************
module tb_rx_serdes_event_status
  import rxes_pkg::*;
;
  logic clock, reset_n, txEnable, rxEnable, hostRead, hostWrite, readValid, irq;
  logic [EOF_LEN_W-1:0] eofLength;
  logic [CHANNELS-1:0] bitTick, bitValid, bitData;
  logic [7:0] hostAddr, hostWriteData, readData, expF, expEn;
  logic [1:0] expFull;
  int failures, nTests, cycles;

  rxes_top rxes_top_i (.clock(clock), .reset_n(reset_n), .txEnable(txEnable), .rxEnable(rxEnable),
    .eofLength(eofLength), .bitTick(bitTick), .bitValid(bitValid), .bitData(bitData),
    .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite), .hostWriteData(hostWriteData),
    .readData(readData), .readValid(readValid), .irq(irq));

  rxes_host_model rxes_host_model_i (.clock(clock), .hostAddr(hostAddr), .hostRead(hostRead),
    .hostWrite(hostWrite), .hostWriteData(hostWriteData), .readData(readData), .readValid(readValid));

  // Free running clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (failures == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Expected interrupt: byte-complete bits can never contribute
  function automatic logic expIrq();
    return |(expF & expEn & 8'h77);
  endfunction : expIrq

  // Mask of the low k received bits
  function automatic logic [7:0] maskOf(input int k);
    return 8'((1 << k) - 1);
  endfunction : maskOf

  task automatic checkIrq();
    repeat (3) @(posedge clock);
    check({7'h00, irq}, {7'h00, expIrq()});
  endtask : checkIrq

  task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
    logic [7:0] got;
    logic ok;
    rxes_host_model_i.regRead(addr, got, ok);
    check({7'h00, ok}, 8'h01);
    check(got & mask, exp);
  endtask : readCheck

  // Status read; everything but byte-complete clears
  task automatic readStatus();
    readCheck(ADDR_RX_EVENT_FLAGS, expF);
    expF = expF & 8'h88;
  endtask : readStatus

  // Data read empties the holding register; an empty one flags underflow
  task automatic readHold(input int ch, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
    logic [7:0] got;
    logic ok;
    if (expFull[ch]) begin
      readCheck(ch == 1 ? ADDR_RX_DATA_B : ADDR_RX_DATA_A, exp, mask);
    end else begin
      rxes_host_model_i.regRead(ch == 1 ? ADDR_RX_DATA_B : ADDR_RX_DATA_A, got, ok);
      expF[ch * CH_STRIDE + FLD_FLOW] = 1'b1;
    end
    expFull[ch] = 1'b0;
  endtask : readHold

  // Expected effect of one load into a holding register
  task automatic gotLoad(input int ch, input logic whole);
    if (expFull[ch]) expF[ch * CH_STRIDE + FLD_FLOW] = 1'b1;
    expF[ch * CH_STRIDE + FLD_FULL] = 1'b1;
    expF[ch * CH_STRIDE + FLD_VALID] = whole;
    expFull[ch] = 1'b1;
  endtask : gotLoad

  // One bit time on one channel; data line is inverted once the tick is gone
  task automatic sendBit(input int ch, input logic v, input logic d);
    @(posedge clock);
    bitTick <= 2'(1 << ch);
    bitValid <= {v, v};
    bitData <= {d, d};
    @(posedge clock);
    bitTick <= 2'b00;
    bitData <= {~d, ~d};
  endtask : sendBit

  task automatic sendByte(input int ch, input logic [7:0] b);
    for (int i = 0; i < 8; i++) sendBit(ch, 1'b1, b[i]);
    gotLoad(ch, 1'b1);
  endtask : sendByte

  // Main sequence
  initial begin
    int ch, k, len;
    logic [7:0] d;
    reset_n = 1'b0;
    txEnable = 1'b0;
    rxEnable = 1'b1;
    eofLength = '0;
    bitTick = 2'b00;
    bitValid = 2'b00;
    bitData = 2'b00;
    {expF, expEn, expFull} = '0;
    {failures, nTests, cycles} = '0;
    void'($urandom(5));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    readCheck(ADDR_RX_EVENT_FLAGS, 8'h00);
    readCheck(ADDR_RX_IRQ_ENABLE, 8'h00);
    rxes_host_model_i.regWrite(ADDR_RX_EVENT_FLAGS, 8'hff);
    readCheck(ADDR_RX_EVENT_FLAGS, 8'h00);
    readCheck(8'h20, 8'h00);
    // Whole bytes, then back-to-back overflow and underflow
    for (ch = 0; ch < 2; ch++) begin
      d = 8'($urandom);
      sendByte(ch, d);
      readStatus();
      readHold(ch, d);
      readStatus();
      sendByte(ch, 8'h00);
      sendByte(ch, 8'hff);
      readStatus();
      readStatus();
      readHold(ch, 8'hff);
      readHold(ch, 8'h00);
      readStatus();
    end
    // Partial frames: no end of frame one bit early, then load on the next
    for (int n = 0; n < 6; n++) begin
      ch = n % 2;
      k = (n < 2) ? 1 : 1 + $urandom % 7;
      len = (n < 2) ? 0 : $urandom % 4;
      eofLength <= EOF_LEN_W'(len);
      d = 8'($urandom);
      for (int i = 0; i < k; i++) sendBit(ch, 1'b1, d[i]);
      for (int i = 0; i < len; i++) sendBit(ch, 1'b0, 1'($urandom));
      readStatus();
      sendBit(ch, 1'b0, 1'b0);
      expF[ch * CH_STRIDE + FLD_EOF] = 1'b1;
      gotLoad(ch, 1'b0);
      readStatus();
      readCheck(ch == 1 ? ADDR_RX_MASK_B : ADDR_RX_MASK_A, maskOf(k));
      readHold(ch, d & maskOf(k), maskOf(k));
    end
    // Interrupt enables, first with only byte-complete bits enabled
    for (int n = 0; n < 6; n++) begin
      ch = n % 2;
      expEn = (n == 0) ? 8'h88 : 8'($urandom);
      rxes_host_model_i.regWrite(ADDR_RX_IRQ_ENABLE, expEn);
      readCheck(ADDR_RX_IRQ_ENABLE, expEn);
      d = 8'($urandom);
      sendByte(ch, d);
      if (n > 3) begin
        sendByte(ch, 8'h5a);
        d = 8'h5a;
      end
      checkIrq();
      readStatus();
      checkIrq();
      readHold(ch, d);
    end
    // Leaving receive mode wipes every flag and ignores traffic
    sendByte(0, 8'h3c);
    for (int n = 0; n < 3; n++) begin
      {txEnable, rxEnable} <= (n == 0) ? 2'b00 : (n == 1) ? 2'b10 : 2'b11;
      sendBit(1, 1'b1, 1'b1);
      {expF, expFull} = '0;
      readStatus();
      checkIrq();
    end
    {txEnable, rxEnable} <= 2'b01;
    readStatus();
    end_sim();
  end
endmodule : tb_rx_serdes_event_status
